// >>> logic/cl_uv_pkg.sv
// constants and carriers for the current-limit undervoltage command block
// assumes a PMBus engine on the same clock decodes frames into single commands
package cl_uv_pkg;
    // command codes
    localparam logic [7:0] CMD_UV_LIMIT        = 8'h44;
    localparam logic [7:0] CMD_UV_RESPONSE     = 8'h45;
    localparam logic [7:0] CMD_OC_LIMIT        = 8'h46;
    localparam logic [7:0] CMD_CL_UV_LIMIT     = 8'h48;
    localparam logic [7:0] CMD_CL_UV_RESPONSE  = 8'h49;
    localparam logic [7:0] PHASE_ALL           = 8'hff;
    // response byte layout
    localparam int         RESP_UNUSED_BIT     = 7;
    localparam int         RESP_NOT_IGNORE_BIT = 6;
    localparam int         RESP_RETRY_MSB      = 5;
    localparam int         RESP_RETRY_LSB      = 3;
    localparam int         RESP_DELAY_TOP_BIT  = 2;
    localparam logic [2:0] RETRY_LATCH         = 3'h0;
    localparam logic [2:0] RETRY_HICCUP        = 3'h7;
    localparam logic       NOT_IGNORE_RESET    = 1'h1;
    localparam logic       RETRY_BIT_RESET     = 1'h0;
    localparam logic [1:0] DELAY_SEL_RESET     = 2'h0;
    localparam logic [7:0] OC_CODE_RESET       = 8'h00;
    // timing
    localparam int         CLK_MHZ             = 125;
    localparam int         DELAY_US_0          = 2;
    localparam int         DELAY_US_1          = 16;
    localparam int         DELAY_US_2          = 64;
    localparam int         DELAY_US_3          = 256;
    localparam int         HICCUP_MS           = 52;
    localparam int         TIMER_W             = 24;
    // three-phase stack binning: lower edges and resulting phase codes
    localparam int         STACK3_EDGES        = 13;
    localparam logic [7:0] STACK3_EDGE [0:STACK3_EDGES-1] = '{
        8'h2a, 8'h33, 8'h40, 8'h4b, 8'h55, 8'h62, 8'h6d,
        8'h75, 8'h7e, 8'h8b, 8'h94, 8'h9e, 8'had};
    localparam logic [7:0] PHASE_CODE [0:STACK3_EDGES] = '{
        8'h0d, 8'h0e, 8'h11, 8'h16, 8'h19, 8'h1c, 8'h21,
        8'h25, 8'h27, 8'h2a, 8'h2f, 8'h32, 8'h35, 8'h3a};
    localparam logic [7:0] PHASE_CODE_TOP      = 8'h3a;

    typedef struct packed {
        logic oc_fault;
        logic iout_word;
        logic current_limit_uv_flag;
        logic cml;
        logic ivd;
    } fault_status_t;

    typedef enum logic [1:0] {
        ST_RUN     = 2'b00,
        ST_DELAY   = 2'b01,
        ST_LATCHED = 2'b10,
        ST_HICCUP  = 2'b11
    } uv_state_t;
endpackage

// >>> logic/interval_timer.sv
// down-counting interval timer with one-cycle done indication
// assumes start and clear come from logic on the same clock
`timescale 1ns/100ps
`default_nettype none
module interval_timer #(
    parameter int WIDTH = 24
) (
    input  wire logic             clk_sys_in,
    input  wire logic             reset_in,
    input  wire logic             start_in,
    input  wire logic             clear_in,
    input  wire logic [WIDTH-1:0] load_in,
    output logic                  busy_out,
    output logic                  done_out
);
    logic [WIDTH-1:0] count;

    // done fires load_in cycles after start
    always_ff @(posedge clk_sys_in or posedge reset_in) begin
        if (reset_in) begin
            count <= '0;
        end else if (clear_in) begin
            count <= '0;
        end else if (start_in) begin
            count <= load_in;
        end else if (count != '0) begin
            count <= count - 1'b1;
        end
    end

    assign busy_out = (count != '0);
    assign done_out = (count == WIDTH'(1)) && !clear_in && !start_in;
endmodule
`default_nettype wire

// >>> logic/stack_oc_binner.sv
// bins a three-phase stack overcurrent code into a per-phase code
// assumes the code is the low byte of the written word
`timescale 1ns/100ps
`default_nettype none
module stack_oc_binner
    import cl_uv_pkg::*;
(
    input  wire logic [7:0] stack_code_in,
    output logic      [7:0] phase_code_out
);
    logic [3:0] bin;

    // half-open ranges: each edge passed moves one bin up
    always_comb begin
        bin = 4'h0;
        for (int i = 0; i < STACK3_EDGES; i++) begin
            if (stack_code_in >= STACK3_EDGE[i]) begin
                bin = 4'(i + 1);
            end
        end
        phase_code_out = PHASE_CODE[bin];
    end
endmodule
`default_nettype wire

// >>> logic/cl_uv_fault_regs.sv
// command logic for the undervoltage fault seen while in current limit
// assumes a same-clock PMBus engine; current-limit and enable come from pins
//
// Notes on behaviour
// - three-phase stack overcurrent code binned by half-open ranges, 173 up gives top
// - all-phase overcurrent read answered by primary only, secondaries stay silent
// - primary answers all-phase read with phase level times stack count
// - current-limit threshold reads as live copy of undervoltage limit
// - in current limit, compare output against tracking relative threshold
// - declared fault sets overcurrent, current-word, current_limit_uv_flag flags and alert
// - response bit 7 unused and reads zero
// - not-ignore bit zero: fault ignored, conversion continues
// - not-ignore one: run for delay, then apply retry if fault remains
// - retry 000: latch off until bias cycle or enable toggle
// - retry 111: restart after 52 ms, unlimited attempts
// - retry values other than 000 or 111 rejected as invalid data
// - only retry bit 5 kept, other two rebuilt from it
// - response fields mirror undervoltage response and are read-only here
// - delay select 00/01/10/11 gives 2/16/64/256 us
// - fault gone before delay ends: counter cleared, output stays on
// - hiccup interval fixed at 52 ms whatever the delay
// - delay field top bit held zero and read-only
// - invalid written data: nack, discard, set cml and ivd flags
`timescale 1ns/100ps
`default_nettype none
module cl_uv_fault_regs
    import cl_uv_pkg::*;
#(
    parameter int DELAY0_CYCLES = DELAY_US_0 * CLK_MHZ,
    parameter int DELAY1_CYCLES = DELAY_US_1 * CLK_MHZ,
    parameter int DELAY2_CYCLES = DELAY_US_2 * CLK_MHZ,
    parameter int DELAY3_CYCLES = DELAY_US_3 * CLK_MHZ,
    parameter int HICCUP_CYCLES = HICCUP_MS * 1000 * CLK_MHZ
) (
    input  wire logic          clk_sys_in,
    input  wire logic          reset_in,
    input  wire logic          cmd_valid_in,
    input  wire logic          cmd_write_in,
    input  wire logic [7:0]    cmd_code_in,
    input  wire logic [7:0]    cmd_phase_in,
    input  wire logic [15:0]   cmd_wdata_in,
    input  wire logic [15:0]   uv_limit_in,
    input  wire logic [15:0]   vout_command_in,
    input  wire logic [15:0]   vout_in,
    input  wire logic [3:0]    vout_step_shift_in,
    input  wire logic          current_limit_in,
    input  wire logic          enable_in,
    input  wire logic [2:0]    stack_count_in,
    input  wire logic          primary_in,
    input  wire logic          nvm_restore_in,
    input  wire logic          nvm_retry_bit_in,
    input  wire logic          clear_faults_in,
    output logic               rsp_valid_out,
    output logic               rsp_ack_out,
    output logic               rsp_silent_out,
    output logic [15:0]        rsp_data_out,
    output logic               convert_enable_out,
    output fault_status_t      status_out,
    output logic               alert_pin_out,
    output logic               alert_pin_oe_out
);
    ////////////////////////////////////////////////////////////////////////////
    // pin synchronisers
    logic [1:0]     cl_sync;
    logic [1:0]     en_sync;
    logic           in_limit;
    logic           enabled;

    always_ff @(posedge clk_sys_in or posedge reset_in) begin
        if (reset_in) begin
            cl_sync <= 2'h0;
            en_sync <= 2'h0;
        end else begin
            cl_sync <= {cl_sync[0], current_limit_in};
            en_sync <= {en_sync[0], enable_in};
        end
    end
    assign in_limit = cl_sync[1];
    assign enabled  = en_sync[1];

    ////////////////////////////////////////////////////////////////////////////
    // undervoltage response settings, kept compactly
    logic           not_ignore;
    logic           retry_bit;
    logic [1:0]     delay_sel;
    logic [2:0]     wr_retry;
    logic           wr_is_resp;
    logic           wr_bad_retry;
    logic [7:0]     resp_byte;

    assign wr_is_resp   = cmd_valid_in && cmd_write_in && (cmd_code_in == CMD_UV_RESPONSE);
    assign wr_retry     = cmd_wdata_in[RESP_RETRY_MSB:RESP_RETRY_LSB];
    assign wr_bad_retry = (wr_retry != RETRY_LATCH) && (wr_retry != RETRY_HICCUP);

    always_ff @(posedge clk_sys_in or posedge reset_in) begin
        if (reset_in) begin
            not_ignore <= NOT_IGNORE_RESET;
            retry_bit  <= RETRY_BIT_RESET;
            delay_sel  <= DELAY_SEL_RESET;
        end else if (nvm_restore_in) begin
            retry_bit  <= nvm_retry_bit_in;
        end else if (wr_is_resp && !wr_bad_retry) begin
            not_ignore <= cmd_wdata_in[RESP_NOT_IGNORE_BIT];
            retry_bit  <= cmd_wdata_in[RESP_RETRY_MSB];
            delay_sel  <= cmd_wdata_in[1:0];
        end
    end

    // read-only mirror of the response fields
    always_comb begin
        resp_byte                                   = 8'h00;
        resp_byte[RESP_NOT_IGNORE_BIT]              = not_ignore;
        resp_byte[RESP_RETRY_MSB:RESP_RETRY_LSB]    = {3{retry_bit}};
        resp_byte[1:0]                              = delay_sel;
    end

    ////////////////////////////////////////////////////////////////////////////
    // per-phase overcurrent level and stacked writes
    logic [7:0]     oc_code;
    logic [7:0]     stack3_code;
    logic [7:0]     next_oc_code;
    logic [15:0]    stack_total;

    stack_oc_binner binner (
        .stack_code_in  (cmd_wdata_in[7:0]),
        .phase_code_out (stack3_code)
    );

    always_comb begin
        next_oc_code = {2'h0, cmd_wdata_in[5:0]};
        if (cmd_phase_in == PHASE_ALL) begin
            case (stack_count_in)
                3'h2:    next_oc_code = 8'((9'(cmd_wdata_in[7:0]) + 9'h1) >> 1);
                3'h3:    next_oc_code = stack3_code;
                3'h4:    next_oc_code = 8'((10'(cmd_wdata_in[7:0]) + 10'h2) >> 2);
                default: next_oc_code = {2'h0, cmd_wdata_in[5:0]};
            endcase
        end
    end

    always_ff @(posedge clk_sys_in or posedge reset_in) begin
        if (reset_in) begin
            oc_code <= OC_CODE_RESET;
        end else if (cmd_valid_in && cmd_write_in && (cmd_code_in == CMD_OC_LIMIT)) begin
            oc_code <= next_oc_code;
        end
    end

    assign stack_total = 16'(oc_code * stack_count_in);

    ////////////////////////////////////////////////////////////////////////////
    // command answers; status flags are handled further down
    logic           bad_write;
    logic           unsupported_write;

    assign bad_write         = wr_is_resp && wr_bad_retry;
    assign unsupported_write = cmd_valid_in && cmd_write_in &&
                               ((cmd_code_in == CMD_CL_UV_LIMIT) ||
                                (cmd_code_in == CMD_CL_UV_RESPONSE));

    always_ff @(posedge clk_sys_in or posedge reset_in) begin
        if (reset_in) begin
            rsp_valid_out  <= 1'b0;
            rsp_ack_out    <= 1'b0;
            rsp_silent_out <= 1'b0;
            rsp_data_out   <= 16'h0000;
        end else begin
            rsp_valid_out  <= 1'b0;
            rsp_ack_out    <= 1'b0;
            rsp_silent_out <= 1'b0;
            if (cmd_valid_in && cmd_write_in) begin
                if (bad_write || unsupported_write) begin
                    rsp_valid_out <= 1'b1;
                end else if (cmd_code_in == CMD_UV_RESPONSE) begin
                    rsp_valid_out <= 1'b1;
                    rsp_ack_out   <= 1'b1;
                end else if (cmd_code_in == CMD_OC_LIMIT) begin
                    rsp_valid_out <= 1'b1;
                    rsp_ack_out   <= 1'b1;
                end
            end else if (cmd_valid_in) begin
                if (cmd_code_in == CMD_CL_UV_LIMIT) begin
                    // live copy of the undervoltage limit
                    rsp_valid_out <= 1'b1;
                    rsp_ack_out   <= 1'b1;
                    rsp_data_out  <= uv_limit_in;
                end else if (cmd_code_in == CMD_CL_UV_RESPONSE ||
                             cmd_code_in == CMD_UV_RESPONSE) begin
                    rsp_valid_out <= 1'b1;
                    rsp_ack_out   <= 1'b1;
                    rsp_data_out  <= {8'h00, resp_byte};
                end else if (cmd_code_in == CMD_OC_LIMIT && cmd_phase_in == PHASE_ALL) begin
                    if (primary_in) begin
                        rsp_valid_out <= 1'b1;
                        rsp_ack_out   <= 1'b1;
                        rsp_data_out  <= stack_total;
                    end else begin
                        rsp_silent_out <= 1'b1;
                    end
                end else if (cmd_code_in == CMD_OC_LIMIT) begin
                    rsp_valid_out <= 1'b1;
                    rsp_ack_out   <= 1'b1;
                    rsp_data_out  <= {8'h00, oc_code};
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // tracking threshold and fault condition
    logic [15:0]    uv_offset;
    logic [15:0]    uv_threshold;
    logic           fault_cond;

    // relative threshold, step set by output-voltage mode
    assign uv_offset    = uv_limit_in << vout_step_shift_in;
    assign uv_threshold = (uv_offset > vout_command_in) ? 16'h0000 : vout_command_in - uv_offset;
    assign fault_cond   = in_limit && (vout_in < uv_threshold);

    ////////////////////////////////////////////////////////////////////////////
    // response sequence
    uv_state_t              state;
    uv_state_t              next_state;
    logic                   delay_start;
    logic                   delay_done;
    logic                   hiccup_start;
    logic                   hiccup_done;
    logic                   fault_declare;
    logic [TIMER_W-1:0]     delay_load;

    always_comb begin
        case (delay_sel)
            2'h0:    delay_load = TIMER_W'(DELAY0_CYCLES);
            2'h1:    delay_load = TIMER_W'(DELAY1_CYCLES);
            2'h2:    delay_load = TIMER_W'(DELAY2_CYCLES);
            default: delay_load = TIMER_W'(DELAY3_CYCLES);
        endcase
    end

    interval_timer #(.WIDTH(TIMER_W)) delay_timer (
        .clk_sys_in (clk_sys_in),
        .reset_in   (reset_in),
        .start_in   (delay_start),
        .clear_in   (state == ST_DELAY && !fault_cond),
        .load_in    (delay_load),
        .busy_out   (),
        .done_out   (delay_done)
    );

    interval_timer #(.WIDTH(TIMER_W)) hiccup_timer (
        .clk_sys_in (clk_sys_in),
        .reset_in   (reset_in),
        .start_in   (hiccup_start),
        .clear_in   (!enabled),
        .load_in    (TIMER_W'(HICCUP_CYCLES)),
        .busy_out   (),
        .done_out   (hiccup_done)
    );

    always_comb begin
        next_state    = state;
        delay_start   = 1'b0;
        hiccup_start  = 1'b0;
        fault_declare = 1'b0;
        case (state)
            ST_RUN: begin
                if (enabled && fault_cond && not_ignore) begin
                    delay_start = 1'b1;
                    next_state  = ST_DELAY;
                end
            end
            ST_DELAY: begin
                if (!fault_cond || !enabled) begin
                    next_state = ST_RUN;
                end else if (delay_done) begin
                    fault_declare = 1'b1;
                    if (retry_bit) begin
                        hiccup_start = 1'b1;
                        next_state   = ST_HICCUP;
                    end else begin
                        next_state   = ST_LATCHED;
                    end
                end
            end
            ST_LATCHED: begin
                if (!enabled) begin
                    next_state = ST_RUN;
                end
            end
            default: begin
                if (!enabled || hiccup_done) begin
                    next_state = ST_RUN;
                end
            end
        endcase
    end

    always_ff @(posedge clk_sys_in or posedge reset_in) begin
        if (reset_in) begin
            state              <= ST_RUN;
            convert_enable_out <= 1'b0;
        end else begin
            state              <= next_state;
            convert_enable_out <= enabled && (next_state == ST_RUN || next_state == ST_DELAY);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // sticky status flags and alert; a new event wins over a clear
    fault_status_t  next_status;

    always_comb begin
        next_status = clear_faults_in ? '0 : status_out;
        if (fault_declare) begin
            next_status.oc_fault  = 1'b1;
            next_status.iout_word = 1'b1;
            next_status.current_limit_uv_flag      = 1'b1;
        end
        if (bad_write) begin
            next_status.cml = 1'b1;
            next_status.ivd = 1'b1;
        end
        if (unsupported_write) begin
            next_status.cml = 1'b1;
        end
    end

    always_ff @(posedge clk_sys_in or posedge reset_in) begin
        if (reset_in) begin
            status_out       <= '0;
            alert_pin_out    <= 1'b0;
            alert_pin_oe_out <= 1'b0;
        end else begin
            status_out       <= next_status;
            alert_pin_out    <= 1'b0;
            // alert pulled low while any flag stands
            alert_pin_oe_out <= (next_status != '0);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // checks
    default clocking cb @(posedge clk_sys_in); endclocking
    default disable iff (reset_in);

    chk_resp_unused_zero: assert property (
        rsp_valid_out && rsp_ack_out && $past(cmd_code_in) == CMD_CL_UV_RESPONSE
        && !$past(cmd_write_in) |-> rsp_data_out[RESP_UNUSED_BIT] == 1'b0
        && rsp_data_out[RESP_DELAY_TOP_BIT] == 1'b0) else $error("response reserved bit set");
    chk_retry_bits_equal: assert property (
        rsp_valid_out && $past(cmd_code_in) == CMD_CL_UV_RESPONSE && !$past(cmd_write_in)
        |-> rsp_data_out[5] == rsp_data_out[4] && rsp_data_out[4] == rsp_data_out[3])
        else $error("retry bits differ");
    chk_limit_copy: assert property (
        cmd_valid_in && !cmd_write_in && cmd_code_in == CMD_CL_UV_LIMIT
        |=> rsp_valid_out && rsp_data_out == $past(uv_limit_in)) else $error("limit not mirrored");
    chk_ignore_runs: assert property (
        state == ST_RUN && !not_ignore |=> state == ST_RUN) else $error("ignored fault acted on");
    chk_delay_cleared: assert property (
        state == ST_DELAY && !fault_cond && enabled |=> state == ST_RUN ##1 convert_enable_out)
        else $error("vanished fault not cleared");
    chk_latch_holds: assert property (
        state == ST_LATCHED && enabled |=> state == ST_LATCHED) else $error("latch released");
    chk_fault_flags: assert property (
        fault_declare |=> status_out.oc_fault && status_out.iout_word && status_out.current_limit_uv_flag
        && alert_pin_oe_out && !convert_enable_out) else $error("fault flags missing");
    chk_bad_retry_nack: assert property (
        bad_write |=> rsp_valid_out && !rsp_ack_out && status_out.ivd && status_out.cml
        && $stable(retry_bit)) else $error("invalid retry accepted");
    chk_secondary_silent: assert property (
        cmd_valid_in && !cmd_write_in && cmd_code_in == CMD_OC_LIMIT
        && cmd_phase_in == PHASE_ALL && !primary_in |=> rsp_silent_out && !rsp_valid_out)
        else $error("secondary answered");
    chk_stack_product: assert property (
        cmd_valid_in && !cmd_write_in && cmd_code_in == CMD_OC_LIMIT
        && cmd_phase_in == PHASE_ALL && primary_in
        |=> rsp_data_out == 16'($past(oc_code) * $past(stack_count_in)))
        else $error("stack total wrong");
    chk_bin_top: assert property (
        cmd_valid_in && cmd_write_in && cmd_code_in == CMD_OC_LIMIT && cmd_phase_in == PHASE_ALL
        && stack_count_in == 3'h3 && cmd_wdata_in[7:0] >= 8'had |=> oc_code == PHASE_CODE_TOP)
        else $error("top bin wrong");

    cov_latched: cover property (state == ST_DELAY ##1 state == ST_LATCHED);
    cov_hiccup_restart: cover property (state == ST_HICCUP ##1 state == ST_RUN);
    cov_delay_abort: cover property (state == ST_DELAY ##1 state == ST_RUN);
    cov_all_read: cover property (rsp_valid_out && primary_in && $past(cmd_phase_in) == PHASE_ALL);
endmodule
`default_nettype wire

// >>> testbench/host_model.sv
// host model: sends one decoded command and captures the answer
// assumes answers are registered on the taking edge and read just after it
`timescale 1ns/100ps
`default_nettype none
module host_model (
    input  wire logic        clk_sys_in,
    input  wire logic [18:0] answer_in,
    output logic             cmd_valid_out,
    output logic             cmd_write_out,
    output logic [7:0]       cmd_code_out,
    output logic [15:0]      cmd_wdata_out
);
    initial {cmd_valid_out, cmd_write_out, cmd_code_out, cmd_wdata_out} = 26'h0;
    task automatic xfer(input logic w, input logic [7:0] c, input logic [15:0] d,
                        output logic [18:0] r);
        {cmd_valid_out, cmd_write_out, cmd_code_out, cmd_wdata_out} <= {1'h1, w, c, d};
        @(posedge clk_sys_in);
        cmd_valid_out <= 1'h0;
        // released word flips so a stale copy cannot pass
        cmd_wdata_out <= ~d;
        #1 r = answer_in;
        @(posedge clk_sys_in);
        #1;
    endtask
endmodule
`default_nettype wire

// >>> testbench/cl_uv_fault_regs_test.sv
// bench for the current-limit undervoltage command block
// assumes short delay and hiccup counts passed as parameters
`timescale 1ns/100ps
`default_nettype none
module cl_uv_fault_regs_test;
    import cl_uv_pkg::*;
    logic          clk_sys_in, reset_in, cmd_valid_in, cmd_write_in, current_limit_in;
    logic          enable_in, primary_in, nvm_restore_in, nvm_retry_bit_in, clear_faults_in;
    logic          rsp_valid_out, rsp_ack_out, rsp_silent_out, convert_enable_out;
    logic          alert_pin_out, alert_pin_oe_out;
    logic [7:0]    cmd_code_in, cmd_phase_in;
    logic [15:0]   cmd_wdata_in, uv_limit_in, rsp_data_out, vout_command_in, vout_in;
    logic [3:0]    vout_step_shift_in;
    logic [2:0]    stack_count_in;
    logic [18:0]   r;
    fault_status_t status_out;
    int            error_cnt, checks, n;
    // stack code, expected phase code
    logic [15:0]   bin [4] = '{16'h5419, 16'h551c, 16'hac35, 16'had3a};
    initial begin
        clk_sys_in = 1'h0;
        forever #4 clk_sys_in = ~clk_sys_in;
    end
    cl_uv_fault_regs #(.DELAY0_CYCLES(10), .DELAY1_CYCLES(20), .DELAY2_CYCLES(30),
        .DELAY3_CYCLES(40), .HICCUP_CYCLES(100)) dut (.clk_sys_in, .reset_in, .cmd_valid_in,
        .cmd_write_in, .cmd_code_in, .cmd_phase_in, .cmd_wdata_in, .uv_limit_in,
        .vout_command_in, .vout_in, .vout_step_shift_in,
        .current_limit_in, .enable_in, .stack_count_in, .primary_in, .nvm_restore_in,
        .nvm_retry_bit_in, .clear_faults_in, .rsp_valid_out, .rsp_ack_out, .rsp_silent_out,
        .rsp_data_out, .convert_enable_out, .status_out, .alert_pin_out, .alert_pin_oe_out);
    host_model host (.clk_sys_in, .answer_in({rsp_valid_out, rsp_ack_out, rsp_silent_out,
        rsp_data_out}), .cmd_valid_out(cmd_valid_in), .cmd_write_out(cmd_write_in),
        .cmd_code_out(cmd_code_in), .cmd_wdata_out(cmd_wdata_in));
    ////////////////////////////////////////////////////////////
    task automatic tick(input int k);
        repeat (k) @(posedge clk_sys_in);
        #1;
    endtask
    task automatic give_verdict;
        $display("errors %0d checks %0d", error_cnt, checks);
        if (error_cnt == 0 && checks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    task automatic chk(input logic [23:0] got, input logic [23:0] exp);
        checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // cycles until the stage enable shows lvl, bounded against a hang
    task automatic wait_conv(input logic lvl, input int lo, input int hi);
        for (n = 0; convert_enable_out !== lvl; n++) begin
            if (n == 400) begin
                error_cnt++;
                give_verdict();
            end
            tick(1);
        end
        checks++;
        if (n < lo || n > hi) begin
            error_cnt++;
            $display("wrong value at %0t: got %h expected %h to %h", $time, n, lo, hi);
        end
    endtask
    task automatic talk(input logic w, input logic [7:0] c, input logic [15:0] d,
                        input logic [18:0] e);
        host.xfer(w, c, d, r);
        chk(w ? r[18:16] : r, w ? e[18:16] : e);
    endtask
    task automatic fault_run(input int lo, input int hi);
        current_limit_in <= 1'h1;
        wait_conv(1'h0, lo, hi);
        chk({status_out, alert_pin_oe_out, alert_pin_out}, 7'h72);
        current_limit_in <= 1'h0;
    endtask
    // condition held k cycles must leave the stage running, flags clear
    task automatic no_fault(input int k);
        current_limit_in <= 1'h1;
        tick(k);
        current_limit_in <= 1'h0;
        tick(60);
        chk({convert_enable_out, status_out}, 6'h20);
    endtask
    ////////////////////////////////////////////////////////////
    initial begin
        {reset_in, current_limit_in, nvm_restore_in, nvm_retry_bit_in, clear_faults_in} = 5'h10;
        {enable_in, primary_in, uv_limit_in} = {2'h3, 16'h0123};
        {cmd_phase_in, stack_count_in, vout_step_shift_in} = {8'hff, 3'h3, 4'h0};
        // output just under the tight threshold, so a larger step moves it clear
        {vout_command_in, vout_in} = {16'h1000, 16'h0ff0};
        error_cnt = 0;
        checks = 0;
        repeat (12) @(posedge clk_sys_in);
        reset_in <= 1'h0;
        tick(4);
        talk(1'h0, CMD_CL_UV_RESPONSE, 16'h0, 19'h60040);
        uv_limit_in <= 16'h0004;
        talk(1'h0, CMD_CL_UV_LIMIT, 16'h0, 19'h60004);
        talk(1'h1, CMD_UV_RESPONSE, 16'h007d, 19'h60000);
        talk(1'h1, CMD_UV_RESPONSE, 16'h0050, 19'h40000);
        talk(1'h1, CMD_CL_UV_RESPONSE, 16'h0, 19'h40000);
        talk(1'h0, CMD_CL_UV_RESPONSE, 16'h0, 19'h60079);
        chk(status_out, 5'h03);
        clear_faults_in <= 1'h1;
        tick(1);
        clear_faults_in <= 1'h0;
        foreach (bin[i]) begin
            talk(1'h1, CMD_OC_LIMIT, {8'h00, bin[i][15:8]}, 19'h60000);
            talk(1'h0, CMD_OC_LIMIT, 16'h0, {3'h6, 16'(bin[i][7:0] * 3)});
        end
        // two- and four-phase stacks divide rounding to nearest, halves up, then multiply back
        stack_count_in <= 3'h2;
        talk(1'h1, CMD_OC_LIMIT, 16'h0035, 19'h60000);
        talk(1'h0, CMD_OC_LIMIT, 16'h0, 19'h60036);
        stack_count_in <= 3'h4;
        talk(1'h1, CMD_OC_LIMIT, 16'h0036, 19'h60000);
        talk(1'h0, CMD_OC_LIMIT, 16'h0, 19'h60038);
        primary_in <= 1'h0;
        host.xfer(1'h0, CMD_OC_LIMIT, 16'h0, r);
        chk(r[18:16], 3'h1);
        // a secondary still answers for its own phase
        cmd_phase_in <= 8'h00;
        talk(1'h1, CMD_OC_LIMIT, 16'h00ff, 19'h60000);
        talk(1'h0, CMD_OC_LIMIT, 16'h0, 19'h6003f);
        primary_in <= 1'h1;
        talk(1'h1, CMD_UV_RESPONSE, 16'h0039, 19'h60000);
        no_fault(60);
        talk(1'h1, CMD_UV_RESPONSE, 16'h0079, 19'h60000);
        no_fault(10);
        vout_step_shift_in <= 4'h4;
        no_fault(60);
        vout_step_shift_in <= 4'h0;
        for (int d = 0; d < 4; d++) begin
            talk(1'h1, CMD_UV_RESPONSE, 16'h0078 + 16'(d), 19'h60000);
            fault_run(10 * d + 11, 10 * d + 18);
            wait_conv(1'h1, 96, 104);
            clear_faults_in <= 1'h1;
            tick(1);
            clear_faults_in <= 1'h0;
        end
        nvm_restore_in <= 1'h1;
        tick(1);
        nvm_restore_in <= 1'h0;
        talk(1'h0, CMD_CL_UV_RESPONSE, 16'h0, 19'h60043);
        fault_run(41, 48);
        tick(150);
        chk(convert_enable_out, 1'h0);
        enable_in <= 1'h0;
        tick(4);
        enable_in <= 1'h1;
        wait_conv(1'h1, 1, 8);
        give_verdict();
    end
endmodule
`default_nettype wire
